// file: bench/pcf_host_model.sv
`timescale 1ns/100ps
module pcf_host_model #(
  parameter TICK = 8
) (
  // clock
  input wire sys_clk,
  // command stream
  output reg signed [31:0] geared_delta,
  output reg geared_valid
);
  initial begin
    geared_delta = 32'sh0;
    geared_valid = 1'b0;
  end
  // one increment per period, gap adds idle periods; stream halts on return
  task send(input integer n, input integer step, input integer gap);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(negedge sys_clk);
        geared_delta = step;
        geared_valid = 1'b1;
        @(negedge sys_clk);
        geared_valid = 1'b0;
        geared_delta = ~step;
        repeat (TICK * (gap + 1) - 2) @(negedge sys_clk);
      end
    end
  endtask
endmodule // pcf_host_model

// file: bench/pcf_testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam TICK = 8;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] mode = 2'd0;
  reg dof = 1'b0, posc = 1'b0, gw = 1'b0, gtw = 1'b0, bkp = 1'b0;
  reg [13:0] lag = 14'h0, mas = 14'h0;
  reg [127:0] gin = 128'h0;
  reg [4:0] ev = 5'h0;
  wire signed [31:0] delta, fpos;
  wire valid, dof_resp, bdone, tk;
  wire [13:0] lag_act, fir_act;
  wire [127:0] live, applied, backup;
  integer n_mismatch = 0, n_tests = 0, cyc = 0;

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  pcf_host_model #(.TICK(TICK)) i_pcf_host_model (.sys_clk(sys_clk), .geared_delta(delta),
    .geared_valid(valid));
  pcf_top #(.FIR_DEPTH(2048), .FIR_AW(11), .TICK_CYC(TICK)) i_pcf_top (.sys_clk(sys_clk),
    .rst_n(rst_n), .geared_delta(delta), .geared_valid(valid), .control_mode(mode),
    .two_dof_en(dof), .positioning_complete(posc), .lag_filter_time_setting(lag),
    .moving_average_time_setting(mas), .gear_motor_rev_in(gin[127:96]),
    .gear_shaft_rev_in(gin[95:64]), .feed_in(gin[63:32]), .feed_shaft_rev_in(gin[31:0]),
    .gear_write(gw), .gear_tool_write(gtw), .ev_preoperational_state(ev[0]),
    .ev_homing_done(ev[1]), .ev_multiturn_clear(ev[2]), .ev_tool_op_done(ev[3]),
    .ev_pin_assign(ev[4]), .backup_req(bkp), .filtered_pos(fpos), .cmd_tick(tk),
    .lag_active(lag_act), .fir_active(fir_act), .lag_pending(), .fir_pending(),
    .two_dof_response(dof_resp), .gear_live(live), .gear_applied(applied),
    .gear_backup(backup), .backup_done(bdone));

  task check(input [127:0] seen, input [127:0] exp, input string what);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask

  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  task per(input integer n);
    repeat (n * TICK) @(negedge sys_clk);
  endtask

  // gear objects: writes go live at once, apply only on events
  task t_gear;
    integer k;
    reg [127:0] prev;
    begin
      prev = 128'h0;
      gin = {4{32'h0000_0011}};
      gw = 1'b1;
      @(negedge sys_clk);
      gw = 1'b0;
      check(live, gin, "live field");
      for (k = 0; k < 5; k = k + 1) begin
        gin = {4{32'h0000_0100 + k}};
        gtw = 1'b1;
        @(negedge sys_clk);
        gtw = 1'b0;
        check(live, gin, "live tool");
        check(applied, prev, "applied held");
        ev[k] = 1'b1;
        @(negedge sys_clk);
        ev[k] = 1'b0;
        @(negedge sys_clk);
        check(applied, gin, "applied event");
        prev = gin;
      end
      bkp = 1'b1;
      @(negedge sys_clk);
      bkp = 1'b0;
      check(bdone, 1'b1, "backup done");
      @(negedge sys_clk);
      check(backup, gin, "backup copy");
      $display("test gear done");
    end
  endtask

  task t_dof;
    begin
      dof = 1'b1;
      @(negedge sys_clk);
      check(dof_resp, 1'b1, "response filter on");
      dof = 1'b0;
      @(negedge sys_clk);
      check(dof_resp, 1'b0, "response filter off");
      $display("test two dof done");
    end
  endtask

  // command period boundaries come one period apart
  task t_tick;
    integer c;
    begin
      c = 0;
      while (tk !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
      c = 1;
      while (tk !== 1'b1) begin
        @(negedge sys_clk);
        c = c + 1;
      end
      check(c, TICK, "tick period");
      $display("test tick done");
    end
  endtask

  // zero settings, slow host
  task t_pass;
    integer base;
    begin
      base = fpos;
      i_pcf_host_model.send(5, 7, 1);
      per(2);
      check(fpos, base + 35, "pass through");
      $display("test pass done");
    end
  endtask

  task t_fir(input [13:0] set, input integer lo, input integer hi);
    reg [13:0] old;
    begin
      old = fir_act;
      mas = set;
      i_pcf_host_model.send(3, 1, 0);
      check(fir_act, old, "fir busy");
      per(lo);
      check(fir_act, old, "fir early");
      per(hi - lo);
      check(fir_act, set, "fir applied");
      $display("test fir %0d done", set);
    end
  endtask

  task t_ramp;
    integer base;
    begin
      base = fpos;
      i_pcf_host_model.send(1, 800, 0);
      per(4);
      check((fpos > base + 250) && (fpos < base + 700), 1'b1, "fir ramp");
      per(12);
      check(fpos, base + 800, "fir end");
      $display("test ramp done");
    end
  endtask

  task t_lag;
    integer base;
    begin
      posc = 1'b1;
      lag = 14'd10;
      per(3);
      check(lag_act, 14'd0, "lag held");
      base = fpos;
      i_pcf_host_model.send(1, 100, 0);
      per(2);
      check(lag_act, 14'd10, "lag applied");
      per(100);
      check((fpos >= base + 99) && (fpos <= base + 100), 1'b1, "lag settle");
      $display("test lag done");
    end
  endtask

  task t_mode;
    begin
      mode = 2'd1;
      lag = 14'd20;
      per(3);
      mode = 2'd0;
      per(3);
      check(lag_act, 14'd10, "lag after mode");
      posc = 1'b0;
      i_pcf_host_model.send(1, 1, 0);
      per(2);
      check(lag_act, 14'd10, "lag not complete");
      $display("test mode done");
    end
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end

  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    t_gear;
    t_dof;
    t_tick;
    t_pass;
    t_fir(14'd200, 165, 176);
    t_fir(14'd10, 150, 176);
    t_ramp;
    t_lag;
    t_mode;
    conclude;
  end
endmodule // testbench

// file: bench/pcf_top_props.sv
`timescale 1ns/100ps
module pcf_top_props (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // inputs watched
  input wire geared_valid,
  input wire [1:0] control_mode,
  input wire two_dof_en,
  input wire positioning_complete,
  input wire [13:0] lag_filter_time_setting,
  input wire [13:0] moving_average_time_setting,
  input wire ev_homing_done,
  input wire backup_req,
  // outputs watched
  input wire [13:0] lag_active,
  input wire [13:0] fir_active,
  input wire lag_pending,
  input wire fir_pending,
  input wire two_dof_response,
  input wire [127:0] gear_live,
  input wire [127:0] gear_applied,
  input wire backup_done
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // a new setting differing from the one in use
  sequence lag_req;
    $changed(lag_filter_time_setting) && (lag_filter_time_setting != lag_active);
  endsequence
  sequence fir_req;
    $changed(moving_average_time_setting) && (moving_average_time_setting != fir_active);
  endsequence
  backup_sig_a: assert property (backup_req |=> backup_done)
    else $error("backup done not one cycle after request");
  dof_echo_a: assert property ($past(rst_n) |-> two_dof_response == $past(two_dof_en))
    else $error("response filter flag not following enable");
  gear_take_a: assert property (ev_homing_done |=> gear_applied == $past(gear_live))
    else $error("gear ratio not applied on homing event");
  lag_when_a: assert property ($changed(lag_active) |-> $past(lag_pending)
    && $past(positioning_complete) && $past(control_mode) == 2'd0)
    else $error("lag setting applied outside its switch edge");
  lag_req_a: assert property (lag_req |=> lag_pending)
    else $error("lag change not held pending");
  fir_when_a: assert property ($changed(fir_active) |->
    $past(fir_pending) && !$past(geared_valid))
    else $error("moving average setting applied while commands arrive");
  fir_req_a: assert property (fir_req |=> fir_pending)
    else $error("moving average change not held pending");
  set_range_a: assert property (lag_active <= 14'd10000 && fir_active <= 14'd10000)
    else $error("active setting above range");
endmodule // pcf_top_props

bind pcf_top pcf_top_props i_pcf_top_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .geared_valid(geared_valid), .control_mode(control_mode), .two_dof_en(two_dof_en),
  .positioning_complete(positioning_complete),
  .lag_filter_time_setting(lag_filter_time_setting),
  .moving_average_time_setting(moving_average_time_setting),
  .ev_homing_done(ev_homing_done), .backup_req(backup_req), .lag_active(lag_active),
  .fir_active(fir_active), .lag_pending(lag_pending), .fir_pending(fir_pending),
  .two_dof_response(two_dof_response), .gear_live(gear_live),
  .gear_applied(gear_applied), .backup_done(backup_done));

// file: rtl/pcf_defs.vh
`ifndef PCF_DEFS_VH
`define PCF_DEFS_VH
// command period and setting units
`define PCF_CLK_HZ 250000000
`define PCF_CMD_PERIOD_NS 125000
`define PCF_CMD_PERIOD_CYC ((`PCF_CMD_PERIOD_NS * 250) / 1000)
`define PCF_SET_UNIT_US 100
`define PCF_SET_MAX 14'd10000
`define PCF_FIR_SMALL_LIMIT 14'd100
`define PCF_FIR_PAD_PERIODS 17'd2
`define PCF_FIR_SCALE_NUM 17'd105
`define PCF_FIR_SCALE_DEN 17'd100
`define PCF_UNIT_NUM 17'd4
`define PCF_UNIT_DEN 17'd5
`define PCF_UNIT_ROUND 17'd2
`define PCF_APPLY_DELAY 4'd8
`define PCF_MODE_POS 2'd0
`define PCF_MODE_VEL 2'd1
`define PCF_MODE_TRQ 2'd2
`endif

// file: rtl/pcf_fir_stage.v
`timescale 1ns/100ps
`include "pcf_defs.vh"
// moving average over recursive box window, one sample per tick
module pcf_fir_stage #(
  parameter W = 32,
  parameter DEPTH = 8192,
  parameter AW = 13
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // control
  input wire tick,
  input wire [AW-1:0] taps,
  // data
  input wire signed [W-1:0] din,
  output reg signed [W-1:0] dout
);
  // history of running prefix sums, so a window change stays exact
  reg signed [W+AW:0] hist [0:DEPTH-1];
  reg [AW-1:0] wp;
  reg [AW:0] filled;
  reg signed [W+AW:0] sum;
  wire [AW-1:0] rp = wp - taps;
  wire signed [W+AW:0] next_sum = sum + din;
  // samples before reset count as zero position
  wire signed [W+AW:0] old_sum = ({1'b0, taps} <= filled) ? hist[rp] : {(W+AW+1){1'b0}};
  wire signed [W+AW:0] window = next_sum - old_sum;
  wire signed [W+AW:0] quot = window / $signed({1'b0, taps});
  always @(posedge sys_clk) begin
    if (tick)
      hist[wp] <= next_sum;
  end
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wp <= {AW{1'b0}};
      filled <= {(AW+1){1'b0}};
      sum <= {(W+AW+1){1'b0}};
      dout <= {W{1'b0}};
    end else begin
      if (tick) begin
        wp <= wp + 1'b1;
        sum <= next_sum;
        if (filled != DEPTH)
          filled <= filled + 1'b1;
      end
      if (taps == {AW{1'b0}})
        dout <= din;
      else if (tick)
        dout <= quot[W-1:0];
    end
  end
endmodule // pcf_fir_stage

// file: rtl/pcf_lag_stage.v
`timescale 1ns/100ps
`include "pcf_defs.vh"
// first-order lag, one update per command period
module pcf_lag_stage #(
  parameter W = 32
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // control
  input wire tick,
  input wire [13:0] tc,
  // data
  input wire signed [W-1:0] din,
  output reg signed [W-1:0] dout
);
  // frac accumulator holds fractional position, but truncated steps can leave output settled one pulse short
  reg signed [W+15:0] acc;
  wire signed [W+15:0] err = {din, 16'h0000} - acc;
  // 0.1 ms units to command periods, never zero
  wire [17:0] den = ({4'h0, tc} * 18'd4 + 18'd7) / 18'd5;
  wire signed [W+15:0] step = err / $signed({1'b0, den});
  wire signed [W+15:0] next_acc = acc + step;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      acc <= {(W+16){1'b0}};
      dout <= {W{1'b0}};
    end else if (tc == 14'h0000) begin
      acc <= {din, 16'h0000};
      dout <= din;
    end else if (tick) begin
      acc <= next_acc;
      dout <= next_acc[W+15:16];
    end
  end
endmodule // pcf_lag_stage

// file: rtl/pcf_top.v
`timescale 1ns/100ps
`include "pcf_defs.vh"
module pcf_top #(
  parameter W = 32,
  parameter FIR_DEPTH = 8192,
  parameter FIR_AW = 13,
  parameter TICK_CYC = `PCF_CMD_PERIOD_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // geared command in, one increment per command period
  input wire signed [W-1:0] geared_delta,
  input wire geared_valid,
  // mode and status
  input wire [1:0] control_mode,
  input wire two_dof_en,
  input wire positioning_complete,
  // filter settings
  input wire [13:0] lag_filter_time_setting,
  input wire [13:0] moving_average_time_setting,
  // gear objects, fieldbus and tool editor writes
  input wire [31:0] gear_motor_rev_in,
  input wire [31:0] gear_shaft_rev_in,
  input wire [31:0] feed_in,
  input wire [31:0] feed_shaft_rev_in,
  input wire gear_write,
  input wire gear_tool_write,
  // gear apply events and backup request
  input wire ev_preoperational_state,
  input wire ev_homing_done,
  input wire ev_multiturn_clear,
  input wire ev_tool_op_done,
  input wire ev_pin_assign,
  input wire backup_req,
  // outputs
  output reg signed [W-1:0] filtered_pos,
  output reg cmd_tick,
  output reg [13:0] lag_active,
  output reg [13:0] fir_active,
  output reg lag_pending,
  output reg fir_pending,
  output reg two_dof_response,
  output reg [127:0] gear_live,
  output reg [127:0] gear_applied,
  output reg [127:0] gear_backup,
  output reg backup_done
);
  // command period timer
  reg [15:0] tcnt;
  wire tick = ({16'h0000, tcnt} == TICK_CYC - 1);
  always @(posedge sys_clk) begin
    if (!rst_n)
      tcnt <= 16'h0000;
    else if (tick)
      tcnt <= 16'h0000;
    else
      tcnt <= tcnt + 16'h0001;
  end

  // accumulate increments of the gear-scaled command over one period
  reg signed [W-1:0] period_sum;
  reg signed [W-1:0] cmd_pos;
  reg period_nonzero;
  wire signed [W-1:0] add_in = geared_valid ? geared_delta : {W{1'b0}};
  wire signed [W-1:0] next_sum = period_sum + add_in;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      period_sum <= {W{1'b0}};
      cmd_pos <= {W{1'b0}};
      period_nonzero <= 1'b0;
    end else if (tick) begin
      cmd_pos <= cmd_pos + next_sum;
      period_nonzero <= (next_sum != {W{1'b0}});
      period_sum <= {W{1'b0}};
    end else begin
      period_sum <= next_sum;
    end
  end

  // switch edge: count goes zero to nonzero while positioning complete
  wire in_pos_mode = (control_mode == `PCF_MODE_POS);
  wire lag_edge = tick && (next_sum != {W{1'b0}}) && !period_nonzero
    && positioning_complete && in_pos_mode;

  function [13:0] clamp_set;
    input [13:0] v;
    begin
      clamp_set = (v > `PCF_SET_MAX) ? `PCF_SET_MAX : v;
    end
  endfunction

  // lag setting: capture, apply delay, apply on edge
  reg [13:0] lag_seen;
  reg [13:0] lag_staged;
  reg [3:0] lag_dly;
  reg lag_ready;
  wire [13:0] lag_req = clamp_set(lag_filter_time_setting);
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      lag_seen <= 14'h0000;
      lag_staged <= 14'h0000;
      lag_dly <= 4'h0;
      lag_ready <= 1'b0;
      lag_active <= 14'h0000;
      lag_pending <= 1'b0;
    end else begin
      if (lag_req != lag_seen) begin
        lag_seen <= lag_req;
        lag_staged <= lag_req;
        lag_pending <= 1'b1;
        lag_ready <= 1'b0;
        lag_dly <= `PCF_APPLY_DELAY;
        // change outside position mode is only armed, never forced on a mode change
      end else if (lag_dly != 4'h0) begin
        lag_dly <= lag_dly - 4'h1;
        if (lag_dly == 4'h1)
          lag_ready <= 1'b1;
      end
      if (lag_edge && lag_ready && lag_req == lag_seen) begin
        lag_active <= lag_staged;
        lag_pending <= 1'b0;
        lag_ready <= 1'b0;
      end
      // an edge during the apply delay leaves the change suspended
    end
  end

  // fir wait time in command periods
  // setting in 0.1 ms units to whole command periods, rounded
  function [16:0] to_periods;
    input [13:0] s;
    begin
      to_periods = ({3'b000, s} * `PCF_UNIT_NUM + `PCF_UNIT_ROUND) / `PCF_UNIT_DEN;
    end
  endfunction

  function [16:0] fir_wait;
    input [13:0] s;
    reg [16:0] base;
    reg [23:0] scaled;
    begin
      base = to_periods(s);
      scaled = ({7'h00, base} * `PCF_FIR_SCALE_NUM) / `PCF_FIR_SCALE_DEN;
      if (s < `PCF_FIR_SMALL_LIMIT)
        fir_wait = base + `PCF_FIR_PAD_PERIODS;
      else
        fir_wait = scaled[16:0];
    end
  endfunction

  reg [13:0] fir_seen;
  reg [13:0] fir_staged;
  reg [3:0] fir_dly;
  reg [16:0] quiet_cnt;
  wire [13:0] fir_req = clamp_set(moving_average_time_setting);
  // quiet periods counting the one ending now
  wire [16:0] quiet_now = quiet_cnt + 17'h00001;
  wire fir_quiet_ok = (next_sum == {W{1'b0}}) && (quiet_now >= fir_wait(fir_staged))
    && (quiet_now >= fir_wait(fir_active));
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      fir_seen <= 14'h0000;
      fir_staged <= 14'h0000;
      fir_dly <= 4'h0;
      quiet_cnt <= 17'h00000;
      fir_active <= 14'h0000;
      fir_pending <= 1'b0;
    end else begin
      if (tick) begin
        if (next_sum != {W{1'b0}})
          quiet_cnt <= 17'h00000;
        else if (quiet_cnt != 17'h1fffe)
          quiet_cnt <= quiet_cnt + 17'h00001;
      end
      if (fir_req != fir_seen) begin
        fir_seen <= fir_req;
        fir_staged <= fir_req;
        fir_pending <= 1'b1;
        fir_dly <= `PCF_APPLY_DELAY;
      end else if (fir_dly != 4'h0) begin
        fir_dly <= fir_dly - 4'h1;
      end else if (fir_pending && tick && fir_quiet_ok) begin
        fir_active <= fir_staged;
        fir_pending <= 1'b0;
      end
    end
  end

  // filter chain: lag then moving average
  wire signed [W-1:0] lag_out;
  wire signed [W-1:0] fir_out;
  wire [16:0] fir_span = to_periods(fir_active);
  wire [FIR_AW-1:0] fir_taps = (fir_span >= FIR_DEPTH) ?
    {FIR_AW{1'b1}} : fir_span[FIR_AW-1:0];

  pcf_lag_stage #(.W(W)) u_lag (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .tc(lag_active),
    .din(cmd_pos),
    .dout(lag_out)
  );

  pcf_fir_stage #(.W(W), .DEPTH(FIR_DEPTH), .AW(FIR_AW)) u_fir (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .taps(fir_taps),
    .din(lag_out),
    .dout(fir_out)
  );

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      filtered_pos <= {W{1'b0}};
      cmd_tick <= 1'b0;
      two_dof_response <= 1'b0;
    end else begin
      filtered_pos <= fir_out;
      cmd_tick <= tick;
      two_dof_response <= two_dof_en;
    end
  end

  // gear objects: live, applied, backup
  reg pwr_up;
  wire gear_apply = pwr_up || ev_preoperational_state || ev_homing_done
    || ev_multiturn_clear || ev_tool_op_done || ev_pin_assign;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pwr_up <= 1'b1;
      gear_live <= {128{1'b0}};
      gear_applied <= {128{1'b0}};
      gear_backup <= {128{1'b0}};
      backup_done <= 1'b0;
    end else begin
      pwr_up <= 1'b0;
      if (pwr_up)
        gear_live <= gear_backup;
      else if (gear_write || gear_tool_write)
        gear_live <= {gear_motor_rev_in, gear_shaft_rev_in, feed_in,
          feed_shaft_rev_in};
      if (gear_apply)
        gear_applied <= pwr_up ? gear_backup : gear_live;
      backup_done <= backup_req;
      if (backup_req)
        gear_backup <= gear_live;
    end
  end
endmodule // pcf_top
